// ---- hw/udt_pkg.sv ----
package udt_pkg;

	// Number of timer instances and which of them own a toggle output pin.
	localparam int NUM_TIMERS = 3;
	localparam logic [2:0] TOGGLE_CAPABLE = 3'h5;

	// Register indices; byte address is {timer page, index, 2'b00}.
	localparam logic [7:0] IDX_CTRL = 8'hC8;
	localparam logic [7:0] IDX_CFG = 8'hC9;
	localparam logic [7:0] IDX_RCAP_LO = 8'hCA;
	localparam logic [7:0] IDX_RCAP_HI = 8'hCB;
	localparam logic [7:0] IDX_CNT_LO = 8'hCC;
	localparam logic [7:0] IDX_CNT_HI = 8'hCD;
	localparam int ADDR_W = 12;

	// Control register fields.
	localparam int CTL_WRAP = 7;
	localparam int CTL_EXT_FLAG = 6;
	localparam int CTL_EXT_EN = 3;
	localparam int CTL_RUN = 2;
	localparam int CTL_CSRC = 1;
	localparam int CTL_CAP = 0;
	localparam logic [7:0] CTL_MASK = 8'hCF;

	// Configuration register fields.
	localparam int CFG_DIV_HI = 4;
	localparam int CFG_DIV_LO = 3;
	localparam int CFG_TOG = 2;
	localparam int CFG_TOE = 1;
	localparam int CFG_DCE = 0;
	localparam logic [7:0] CFG_MASK = 8'h1F;
	localparam logic [7:0] CFG_MASK_NOTOG = 8'h1B;

	// Tick source encodings of the clock divide select.
	typedef enum logic [1:0] {
		DIV_SYS12 = 2'h0,
		DIV_SYS1 = 2'h1,
		DIV_EXT8 = 2'h2,
		DIV_SYS2 = 2'h3
	} udt_div_t;

	// Divider ratios.
	localparam int SYS_DIV_SLOW = 12;
	localparam int SYS_DIV_FAST = 2;
	localparam int EXT_DIV = 8;

	// Count limits and reset value.
	localparam logic [15:0] CNT_MAX = 16'hFFFF;
	localparam logic [15:0] CNT_ZERO = 16'h0000;
	localparam logic [15:0] CNT_ONE = 16'h0001;
	localparam logic [7:0] REG_RESET = 8'h00;

endpackage

// ---- hw/udt_pin_sync.sv ----
`timescale 1ns/1ps
module udt_pin_sync (
	// Clock and reset.
	input wire logic pclk,
	input wire logic presetn,
	// Pin from outside the clock domain.
	input wire logic pin,
	// Filtered level and one-cycle falling edge.
	output logic level,
	output logic fall
);
	typedef struct packed {
		logic s1;
		logic s2;
		logic s3;
		logic lvl;
		logic fall;
	} udt_sync_state_t;

	udt_sync_state_t st_r;
	udt_sync_state_t st_nxt;

	// A change is accepted only once the second and third stages agree.
	always_comb
	begin
		st_nxt = st_r;
		st_nxt.s1 = pin;
		st_nxt.s2 = st_r.s1;
		st_nxt.s3 = st_r.s2;
		st_nxt.fall = 1'b0;
		if (st_r.s2 == st_r.s3)
		begin
			st_nxt.lvl = st_r.s3;
			st_nxt.fall = st_r.lvl & ~st_r.s3;
		end
	end

	// Stages idle high and the edge pulse idles low, so release of reset never fakes an edge.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			st_r <= '{s1: 1'b1, s2: 1'b1, s3: 1'b1, lvl: 1'b1, fall: 1'b0};
		else
			st_r <= st_nxt;
	end

	assign level = st_r.lvl;
	assign fall = st_r.fall;

	property p_fall_edge;
		@(posedge pclk) disable iff (!presetn)
		fall |-> !level && $past(level);
	endproperty
	a_fall_edge: assert property (p_fall_edge) else $error("fall without level drop");
endmodule // udt_pin_sync

// ---- hw/udt_prescale.sv ----
`timescale 1ns/1ps
module udt_prescale #(
	parameter int SLOW_DIV = udt_pkg::SYS_DIV_SLOW,
	parameter int FAST_DIV = udt_pkg::SYS_DIV_FAST,
	parameter int EXT_DIV = udt_pkg::EXT_DIV
) (
	// Clock and reset.
	input wire logic pclk,
	input wire logic presetn,
	// Synchronised falling edge of the external oscillator.
	input wire logic ext_fall,
	// One-cycle ticks of the three divided sources.
	output logic tick_slow,
	output logic tick_fast,
	output logic tick_ext
);
	localparam int SW = $clog2(SLOW_DIV);
	localparam int FW = $clog2(FAST_DIV);
	localparam int EW = $clog2(EXT_DIV);

	if (SLOW_DIV < 2 || FAST_DIV < 2 || EXT_DIV < 2)
	begin : g_bad
		$error("Divider ratios below two are not supported.");
	end

	typedef struct packed {
		logic [SW-1:0] slow;
		logic [FW-1:0] fast;
		logic [EW-1:0] ext;
		logic ts;
		logic tf;
		logic te;
	} udt_pre_state_t;

	udt_pre_state_t st_r;
	udt_pre_state_t st_nxt;

	// Free-running dividers; the external one advances only on oscillator edges.
	always_comb
	begin
		st_nxt = st_r;
		st_nxt.ts = (st_r.slow == SW'(SLOW_DIV - 1));
		st_nxt.slow = st_nxt.ts ? '0 : SW'(st_r.slow + 1'b1);
		st_nxt.tf = (st_r.fast == FW'(FAST_DIV - 1));
		st_nxt.fast = st_nxt.tf ? '0 : FW'(st_r.fast + 1'b1);
		st_nxt.te = 1'b0;
		if (ext_fall)
		begin
			st_nxt.te = (st_r.ext == EW'(EXT_DIV - 1));
			st_nxt.ext = st_nxt.te ? '0 : EW'(st_r.ext + 1'b1);
		end
	end

	// State register.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			st_r <= '0;
		else
			st_r <= st_nxt;
	end

	assign tick_slow = st_r.ts;
	assign tick_fast = st_r.tf;
	assign tick_ext = st_r.te;

	property p_fast_period;
		@(posedge pclk) disable iff (!presetn)
		tick_fast |=> !tick_fast ##1 tick_fast;
	endproperty
	a_fast_period: assert property (p_fast_period) else $error("fast tick not every 2");
endmodule // udt_prescale

// ---- hw/udt_timer_top.sv ----
`timescale 1ns/1ps
module udt_timer_top (
	// Clock and reset.
	input wire logic pclk,
	input wire logic presetn,
	// APB slave.
	input wire logic [udt_pkg::ADDR_W-1:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// External pins; the shared pair serves the first two timers.
	input wire logic shared_count_pin,
	input wire logic shared_trigger_pin,
	input wire logic ext_count_pin,
	input wire logic ext_trigger_pin,
	input wire logic ext_osc_clk,
	// Toggle outputs of the first and third timers.
	output logic toggle_out_a,
	output logic toggle_oe_a,
	output logic toggle_out_c,
	output logic toggle_oe_c,
	// Events towards the rest of the chip.
	output logic [udt_pkg::NUM_TIMERS-1:0] irq_req,
	output logic [udt_pkg::NUM_TIMERS-1:0] overflow_pulse,
	output logic [1:0] adc_conv_start
);
	localparam int NT = udt_pkg::NUM_TIMERS;

	typedef struct packed {
		logic [NT-1:0][7:0] ctrl;
		logic [NT-1:0][7:0] cfg;
		logic [NT-1:0][15:0] rcap;
		logic [NT-1:0][15:0] cnt;
		logic [NT-1:0] ovf;
		logic [NT-1:0] irq;
		logic [31:0] rdata;
		logic ready;
		logic slverr;
	} udt_top_state_t;

	udt_top_state_t st_r;
	udt_top_state_t st_nxt;

	// Synchronised pin views, indexed by timer.
	logic cnt_pin_fall_a;
	logic cnt_pin_fall_c;
	logic trg_level_a;
	logic trg_level_c;
	logic trg_fall_a;
	logic trg_fall_c;
	logic osc_fall;
	logic tick_slow;
	logic tick_fast;
	logic tick_ext;
	logic [NT-1:0] cnt_fall;
	logic [NT-1:0] trg_level;
	logic [NT-1:0] trg_fall;

	// Per-timer decisions, visible to the checks below.
	logic [NT-1:0] run_w;
	logic [NT-1:0] step_w;
	logic [NT-1:0] down_w;
	logic [NT-1:0] ext_w;
	logic [NT-1:0] wrap_w;
	logic wr_any;

	// True when the address selects register idx of timer t.
	function automatic logic udt_hit(input logic [udt_pkg::ADDR_W-1:0] addr,
		input int t, input logic [7:0] idx);
		udt_hit = (addr == {2'(t), idx, 2'h0});
	endfunction

	// Every pin passes one synchroniser; the shared pair is synchronised once and fanned out to two timers.
	udt_pin_sync u_cnt_a (.pclk(pclk), .presetn(presetn), .pin(shared_count_pin),
		.level(), .fall(cnt_pin_fall_a));
	udt_pin_sync u_cnt_c (.pclk(pclk), .presetn(presetn), .pin(ext_count_pin),
		.level(), .fall(cnt_pin_fall_c));
	udt_pin_sync u_trg_a (.pclk(pclk), .presetn(presetn), .pin(shared_trigger_pin),
		.level(trg_level_a), .fall(trg_fall_a));
	udt_pin_sync u_trg_c (.pclk(pclk), .presetn(presetn), .pin(ext_trigger_pin),
		.level(trg_level_c), .fall(trg_fall_c));
	udt_pin_sync u_osc (.pclk(pclk), .presetn(presetn), .pin(ext_osc_clk),
		.level(), .fall(osc_fall));

	// One prescaler feeds all timers so their ticks stay in phase.
	udt_prescale u_pre (
		.pclk(pclk),
		.presetn(presetn),
		.ext_fall(osc_fall),
		.tick_slow(tick_slow),
		.tick_fast(tick_fast),
		.tick_ext(tick_ext)
	);

	// The middle timer sees exactly what the first one sees.
	assign cnt_fall = {cnt_pin_fall_c, cnt_pin_fall_a, cnt_pin_fall_a};
	assign trg_level = {trg_level_c, trg_level_a, trg_level_a};
	assign trg_fall = {trg_fall_c, trg_fall_a, trg_fall_a};

	// Bus slave, counting engines and flags in one next-state function.
	always_comb
	begin
		logic [7:0] ctl;
		logic [7:0] cfg;
		logic [15:0] cnt;
		logic [15:0] rcap;
		logic [7:0] wb;
		logic tick;
		ctl = '0;
		cfg = '0;
		cnt = '0;
		rcap = '0;
		wb = pwdata[7:0];
		tick = 1'b0;
		st_nxt = st_r;
		run_w = '0;
		step_w = '0;
		down_w = '0;
		ext_w = '0;
		wrap_w = '0;
		wr_any = psel & penable & st_r.ready & pwrite;
		// Answer in the access cycle that follows every setup cycle.
		st_nxt.ready = psel & ~penable;
		st_nxt.slverr = 1'b0;
		st_nxt.ovf = '0;
		if (psel & ~penable)
		begin
			st_nxt.rdata = '0;
			st_nxt.slverr = 1'b1;
			for (int t = 0; t < NT; t++)
			begin
				if (udt_hit(paddr, t, udt_pkg::IDX_CTRL))
					st_nxt.rdata[7:0] = st_r.ctrl[t];
				if (udt_hit(paddr, t, udt_pkg::IDX_CFG))
					st_nxt.rdata[7:0] = st_r.cfg[t];
				if (udt_hit(paddr, t, udt_pkg::IDX_RCAP_LO))
					st_nxt.rdata[7:0] = st_r.rcap[t][7:0];
				if (udt_hit(paddr, t, udt_pkg::IDX_RCAP_HI))
					st_nxt.rdata[7:0] = st_r.rcap[t][15:8];
				if (udt_hit(paddr, t, udt_pkg::IDX_CNT_LO))
					st_nxt.rdata[7:0] = st_r.cnt[t][7:0];
				if (udt_hit(paddr, t, udt_pkg::IDX_CNT_HI))
					st_nxt.rdata[7:0] = st_r.cnt[t][15:8];
				if (udt_hit(paddr, t, udt_pkg::IDX_CTRL) || udt_hit(paddr, t, udt_pkg::IDX_CFG)
					|| udt_hit(paddr, t, udt_pkg::IDX_RCAP_LO)
					|| udt_hit(paddr, t, udt_pkg::IDX_RCAP_HI)
					|| udt_hit(paddr, t, udt_pkg::IDX_CNT_LO)
					|| udt_hit(paddr, t, udt_pkg::IDX_CNT_HI))
					st_nxt.slverr = 1'b0;
			end
		end
		for (int t = 0; t < NT; t++)
		begin
			ctl = st_r.ctrl[t];
			cfg = st_r.cfg[t];
			cnt = st_r.cnt[t];
			rcap = st_r.rcap[t];
			// Tick source selection.
			unique case (udt_pkg::udt_div_t'(cfg[udt_pkg::CFG_DIV_HI:udt_pkg::CFG_DIV_LO]))
				udt_pkg::DIV_SYS12: tick = tick_slow;
				udt_pkg::DIV_SYS1: tick = 1'b1;
				udt_pkg::DIV_EXT8: tick = tick_ext;
				udt_pkg::DIV_SYS2: tick = tick_fast;
			endcase
			run_w[t] = ctl[udt_pkg::CTL_RUN];
			step_w[t] = run_w[t] & (ctl[udt_pkg::CTL_CSRC] ? cnt_fall[t] : tick);
			down_w[t] = cfg[udt_pkg::CFG_DCE] & ~trg_level[t];
			ext_w[t] = run_w[t] & ctl[udt_pkg::CTL_EXT_EN] & ~cfg[udt_pkg::CFG_DCE]
				& trg_fall[t];
			// Counting; an external reload outranks a step in the same cycle.
			if (ctl[udt_pkg::CTL_CAP])
			begin
				if (ext_w[t])
					st_nxt.rcap[t] = cnt;
				if (step_w[t] && down_w[t])
				begin
					wrap_w[t] = (cnt == udt_pkg::CNT_ZERO);
					st_nxt.cnt[t] = 16'(cnt - udt_pkg::CNT_ONE);
				end
				else if (step_w[t])
				begin
					wrap_w[t] = (cnt == udt_pkg::CNT_MAX);
					st_nxt.cnt[t] = 16'(cnt + udt_pkg::CNT_ONE);
				end
			end
			else if (ext_w[t])
				st_nxt.cnt[t] = rcap;
			else if (step_w[t] && down_w[t])
			begin
				wrap_w[t] = (cnt == rcap);
				st_nxt.cnt[t] = wrap_w[t] ? udt_pkg::CNT_MAX : 16'(cnt - udt_pkg::CNT_ONE);
			end
			else if (step_w[t])
			begin
				wrap_w[t] = (cnt == udt_pkg::CNT_MAX);
				st_nxt.cnt[t] = wrap_w[t] ? rcap : 16'(cnt + udt_pkg::CNT_ONE);
			end
			// Software writes land on top of the hardware result.
			if (wr_any && udt_hit(paddr, t, udt_pkg::IDX_CTRL))
				st_nxt.ctrl[t] = wb & udt_pkg::CTL_MASK;
			if (wr_any && udt_hit(paddr, t, udt_pkg::IDX_CFG))
				st_nxt.cfg[t] = wb & (udt_pkg::TOGGLE_CAPABLE[t] ? udt_pkg::CFG_MASK
					: udt_pkg::CFG_MASK_NOTOG);
			if (wr_any && udt_hit(paddr, t, udt_pkg::IDX_RCAP_LO))
				st_nxt.rcap[t][7:0] = wb;
			if (wr_any && udt_hit(paddr, t, udt_pkg::IDX_RCAP_HI))
				st_nxt.rcap[t][15:8] = wb;
			if (wr_any && udt_hit(paddr, t, udt_pkg::IDX_CNT_LO))
				st_nxt.cnt[t][7:0] = wb;
			if (wr_any && udt_hit(paddr, t, udt_pkg::IDX_CNT_HI))
				st_nxt.cnt[t][15:8] = wb;
			// Flags are only ever set or inverted here, so a set beats a clear.
			if (wrap_w[t])
				st_nxt.ctrl[t][udt_pkg::CTL_WRAP] = 1'b1;
			if (ext_w[t])
				st_nxt.ctrl[t][udt_pkg::CTL_EXT_FLAG] = 1'b1;
			else if (wrap_w[t] && !ctl[udt_pkg::CTL_CAP])
				st_nxt.ctrl[t][udt_pkg::CTL_EXT_FLAG] =
					~st_nxt.ctrl[t][udt_pkg::CTL_EXT_FLAG];
			// A forced toggle level written this cycle wins over the inversion.
			if (udt_pkg::TOGGLE_CAPABLE[t] && wrap_w[t] && cfg[udt_pkg::CFG_TOE]
				&& !(wr_any && udt_hit(paddr, t, udt_pkg::IDX_CFG)))
				st_nxt.cfg[t][udt_pkg::CFG_TOG] = ~cfg[udt_pkg::CFG_TOG];
			st_nxt.ovf[t] = wrap_w[t];
			// The reload flag toggling of auto-reload mode must not interrupt.
			st_nxt.irq[t] = st_nxt.ctrl[t][udt_pkg::CTL_WRAP]
				| (st_nxt.ctrl[t][udt_pkg::CTL_EXT_FLAG] & st_nxt.ctrl[t][udt_pkg::CTL_CAP]);
		end
	end

	// State register; every field starts at zero.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			st_r <= '0;
		else
			st_r <= st_nxt;
	end

	// Outputs straight from the state register.
	assign prdata = st_r.rdata;
	assign pready = st_r.ready;
	assign pslverr = st_r.slverr;
	assign toggle_out_a = st_r.cfg[0][udt_pkg::CFG_TOG];
	assign toggle_oe_a = st_r.cfg[0][udt_pkg::CFG_TOE];
	assign toggle_out_c = st_r.cfg[2][udt_pkg::CFG_TOG];
	assign toggle_oe_c = st_r.cfg[2][udt_pkg::CFG_TOE];
	assign irq_req = st_r.irq;
	assign overflow_pulse = st_r.ovf;
	assign adc_conv_start = st_r.ovf[1:0];

	default clocking udt_cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	sequence s_setup;
		psel && !penable;
	endsequence
	property p_apb_answer;
		s_setup |=> pready ##1 !pready;
	endproperty
	a_apb_answer: assert property (p_apb_answer) else $error("APB answer not one cycle");

	// Checks per timer.
	for (genvar g = 0; g < NT; g++)
	begin : g_chk
		sequence s_quiet;
			!wr_any && !ext_w[g];
		endsequence
		sequence s_cap_up_top;
			st_r.ctrl[g][udt_pkg::CTL_CAP] && step_w[g] && !down_w[g]
				&& st_r.cnt[g] == udt_pkg::CNT_MAX && !wr_any;
		endsequence
		sequence s_ar_dn_hit;
			(!st_r.ctrl[g][udt_pkg::CTL_CAP] && step_w[g] && down_w[g]
				&& st_r.cnt[g] == st_r.rcap[g]) ##0 s_quiet;
		endsequence
		property p_hold;
			!run_w[g] && !wr_any |=> $stable(st_r.cnt[g]) && $stable(st_r.rcap[g]);
		endproperty
		a_hold: assert property (p_hold) else $error("count moved while stopped");
		property p_cap_wrap;
			s_cap_up_top |=> st_r.cnt[g] == udt_pkg::CNT_ZERO && st_r.ctrl[g][udt_pkg::CTL_WRAP];
		endproperty
		a_cap_wrap: assert property (p_cap_wrap) else $error("capture overflow wrong");
		property p_cap_under;
			st_r.ctrl[g][udt_pkg::CTL_CAP] && step_w[g] && down_w[g] && !wr_any
				&& st_r.cnt[g] == udt_pkg::CNT_ZERO |=> st_r.cnt[g] == udt_pkg::CNT_MAX
				&& st_r.ctrl[g][udt_pkg::CTL_WRAP]
				##1 (st_r.ctrl[g][udt_pkg::CTL_WRAP] || $past(wr_any));
		endproperty
		a_cap_under: assert property (p_cap_under) else $error("capture underflow wrong");
		property p_capture;
			st_r.ctrl[g][udt_pkg::CTL_CAP] && ext_w[g] && !wr_any |=>
				st_r.rcap[g] == $past(st_r.cnt[g]) && st_r.ctrl[g][udt_pkg::CTL_EXT_FLAG];
		endproperty
		a_capture: assert property (p_capture) else $error("capture lost");
		property p_ar_reload;
			!st_r.ctrl[g][udt_pkg::CTL_CAP] && step_w[g] && !down_w[g] && !wr_any && !ext_w[g]
				&& st_r.cnt[g] == udt_pkg::CNT_MAX |=> st_r.cnt[g] == $past(st_r.rcap[g]);
		endproperty
		a_ar_reload: assert property (p_ar_reload) else $error("overflow did not reload");
		property p_ar_under;
			s_ar_dn_hit |=> st_r.cnt[g] == udt_pkg::CNT_MAX;
		endproperty
		a_ar_under: assert property (p_ar_under) else $error("underflow did not load top");
		property p_ext_reload;
			!st_r.ctrl[g][udt_pkg::CTL_CAP] && ext_w[g] && !wr_any |=>
				st_r.cnt[g] == $past(st_r.rcap[g]);
		endproperty
		a_ext_reload: assert property (p_ext_reload) else $error("edge reload lost");
		property p_dce_no_event;
			st_r.cfg[g][udt_pkg::CFG_DCE] |-> !ext_w[g];
		endproperty
		a_dce_no_event: assert property (p_dce_no_event) else $error("event with down count");
		property p_exf_toggle;
			!st_r.ctrl[g][udt_pkg::CTL_CAP] && wrap_w[g] && !wr_any |=>
				st_r.ctrl[g][udt_pkg::CTL_EXT_FLAG] != $past(st_r.ctrl[g][udt_pkg::CTL_EXT_FLAG]);
		endproperty
		a_exf_toggle: assert property (p_exf_toggle) else $error("17th bit did not flip");
		property p_up_step;
			(step_w[g] && !down_w[g] && !wrap_w[g]) ##0 s_quiet |=>
				st_r.cnt[g] == 16'($past(st_r.cnt[g]) + udt_pkg::CNT_ONE);
		endproperty
		a_up_step: assert property (p_up_step) else $error("up step wrong");
		property p_wrap_out;
			wrap_w[g] |=> overflow_pulse[g] && st_r.ctrl[g][udt_pkg::CTL_WRAP];
		endproperty
		a_wrap_out: assert property (p_wrap_out) else $error("wrap not reported");
		if (udt_pkg::TOGGLE_CAPABLE[g])
		begin : g_tog
			property p_toggle;
				wrap_w[g] && st_r.cfg[g][udt_pkg::CFG_TOE] && !wr_any |=>
					st_r.cfg[g][udt_pkg::CFG_TOG] != $past(st_r.cfg[g][udt_pkg::CFG_TOG]);
			endproperty
			a_toggle: assert property (p_toggle) else $error("output did not toggle");
		end
	end
endmodule // udt_timer_top

// ---- bench/udt_tb.sv ----
`timescale 1ns/1ps
module testbench;

	// Bus, pin and output signals of the timer block.
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err, osc;
	logic [udt_pkg::ADDR_W-1:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [3:0] pins;
	logic ta, oa, tc, oc;
	logic [2:0] irq, ovf;

	// Reference model state and bench counters.
	int cnt_m[3], rel_m[3], exf_m[3], wrap_m[3], wn[3], ovn[3];
	int divs[4] = '{12, 1, 64, 2};
	int mismatches, checked, cyc;

	udt_timer_top i_udt_timer_top (
		.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
		.pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .shared_count_pin(pins[0]), .shared_trigger_pin(pins[1]),
		.ext_count_pin(pins[2]), .ext_trigger_pin(pins[3]), .ext_osc_clk(osc),
		.toggle_out_a(ta), .toggle_oe_a(oa), .toggle_out_c(tc), .toggle_oe_c(oc),
		.irq_req(irq), .overflow_pulse(ovf), .adc_conv_start()
	);

	// Free-running clock at 250 MHz.
	initial
	begin
		pclk = 1'b0;
		forever #2 pclk = ~pclk;
	end

	// Cycle count, a slow oscillator, wrap pulse tally and the hang limit.
	always @(posedge pclk)
	begin
		cyc <= cyc + 1;
		osc <= cyc[2];
		foreach (ovn[i]) ovn[i] += int'(ovf[i] === 1'b1);
		if (cyc == 30000)
		begin
			mismatches++;
			final_report();
		end
	end

	task automatic final_report;
		$display("mismatches=%0d checked=%0d", mismatches, checked);
		if (mismatches == 0 && checked > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		checked++;
		if (got !== exp)
		begin
			mismatches++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// One APB transfer; the request holds until pready is seen at an edge.
	task automatic apb(input int t, input logic [7:0] idx, input logic wr, input logic [7:0] d);
		@(posedge pclk);
		paddr <= {2'(t), idx, 2'h0};
		pwrite <= wr;
		pwdata <= {24'h0, d};
		psel <= 1'b1;
		penable <= 1'b0;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1)
			@(posedge pclk);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wr16(input int t, input logic [7:0] lo, input logic [15:0] v);
		apb(t, lo, 1'b1, v[7:0]);
		apb(t, lo + 8'h01, 1'b1, v[15:8]);
	endtask

	task automatic rd16(input int t, input logic [7:0] lo, output logic [15:0] v);
		apb(t, lo, 1'b0, 8'h00);
		v[7:0] = rd[7:0];
		apb(t, lo + 8'h01, 1'b0, 8'h00);
		v[15:8] = rd[7:0];
	endtask

	// Pulse pins low long enough for the synchroniser, then let the step land.
	task automatic pulse(input logic [3:0] m);
		@(posedge pclk);
		pins <= pins & ~m;
		repeat (4) @(posedge pclk);
		pins <= pins | m;
		repeat (8) @(posedge pclk);
	endtask

	// Model of one count step; the wrap sets the flag, and in reload mode flips the event flag.
	task automatic mstep(input int t, input int dn, input int arl);
		int w;
		w = dn ? (arl ? cnt_m[t] == rel_m[t] : cnt_m[t] == 0) : cnt_m[t] == 65535;
		cnt_m[t] = (dn ? cnt_m[t] - 1 : cnt_m[t] + 1) & 65535;
		if (w)
		begin
			cnt_m[t] = dn ? 65535 : (arl ? rel_m[t] : 0);
			wrap_m[t] = 1;
			exf_m[t] ^= arl;
			wn[t]++;
		end
	endtask

	task automatic chkall(input int t);
		logic [15:0] v;
		rd16(t, udt_pkg::IDX_CNT_LO, v);
		chk(v, 16'(cnt_m[t]));
		apb(t, udt_pkg::IDX_CTRL, 1'b0, 8'h00);
		chk(16'(rd[7:6]), 16'(wrap_m[t] * 2 + exf_m[t]));
		chk(16'(ovn[t]), 16'(wn[t]));
	endtask

	// Main sequence.
	initial
	begin
		logic [15:0] v, capv;
		int d;
		{psel, penable, pwrite, presetn} = 4'h0;
		paddr = '0;
		pwdata = '0;
		pins = 4'hF;
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		void'($urandom(96));
		// All registers of all timers start at zero.
		for (int t = 0; t < 3; t++)
			for (int i = 0; i < 6; i++)
			begin
				apb(t, udt_pkg::IDX_CTRL + 8'(i), 1'b0, 8'h00);
				chk(rd[15:0], 16'h0000);
			end
		// An unmapped place answers with an error.
		apb(0, 8'h10, 1'b1, 8'hFF);
		chk(16'(err), 16'h0001);
		// Pin counting in reload mode, each timer starting close to the top.
		for (int t = 0; t < 3; t++)
		begin
			v = 16'($urandom);
			rel_m[t] = v;
			cnt_m[t] = 65535 - t;
			wr16(t, udt_pkg::IDX_RCAP_LO, v);
			wr16(t, udt_pkg::IDX_CNT_LO, 16'(cnt_m[t]));
			apb(t, udt_pkg::IDX_CFG, 1'b1, 8'h02);
			apb(t, udt_pkg::IDX_CTRL, 1'b1, 8'h06);
		end
		repeat (3)
		begin
			pulse(4'h5);
			mstep(0, 0, 1);
			mstep(1, 0, 1);
			mstep(2, 0, 1);
		end
		for (int t = 0; t < 3; t++)
			chkall(t);
		chk({14'h0, ta, tc}, 16'(2 * (wn[0] % 2) + wn[2] % 2));
		chk(16'(irq), 16'h0007);
		// Software clears flags and stops; nothing moves afterwards.
		for (int t = 0; t < 3; t++)
		begin
			apb(t, udt_pkg::IDX_CTRL, 1'b1, 8'h00);
			wrap_m[t] = 0;
			exf_m[t] = 0;
		end
		pulse(4'h5);
		chkall(0);
		chk(16'(irq), 16'h0000);
		// Forcing the toggle level; the middle timer has no toggle bit.
		apb(0, udt_pkg::IDX_CFG, 1'b1, 8'h02);
		apb(1, udt_pkg::IDX_CFG, 1'b1, 8'h06);
		apb(1, udt_pkg::IDX_CFG, 1'b0, 8'h00);
		chk(16'({ta, oa, rd[2:0]}), 16'h000A);
		// Capture of a static count on a trigger fall.
		v = 16'($urandom);
		cnt_m[2] = v;
		capv = v;
		wr16(2, udt_pkg::IDX_CNT_LO, v);
		apb(2, udt_pkg::IDX_CTRL, 1'b1, 8'h0F);
		pulse(4'h8);
		exf_m[2] = 1;
		rd16(2, udt_pkg::IDX_RCAP_LO, v);
		chk(v, capv);
		chkall(2);
		chk(16'(irq[2]), 16'h0001);
		// Down count from zero; the trigger fall only gives direction.
		apb(2, udt_pkg::IDX_CTRL, 1'b1, 8'h0F);
		exf_m[2] = 0;
		cnt_m[2] = 0;
		wr16(2, udt_pkg::IDX_CNT_LO, 16'h0000);
		apb(2, udt_pkg::IDX_CFG, 1'b1, 8'h01);
		@(posedge pclk);
		pins[3] <= 1'b0;
		pulse(4'h4);
		mstep(2, 1, 0);
		chkall(2);
		rd16(2, udt_pkg::IDX_RCAP_LO, v);
		chk(v, capv);
		// Reload-mode down count: reaching the reload value loads all ones.
		pins[3] <= 1'b1;
		apb(0, udt_pkg::IDX_CFG, 1'b1, 8'h01);
		cnt_m[0] = (rel_m[0] + 1) & 65535;
		wr16(0, udt_pkg::IDX_CNT_LO, 16'(cnt_m[0]));
		pins[1] <= 1'b0;
		apb(0, udt_pkg::IDX_CTRL, 1'b1, 8'h06);
		repeat (2)
		begin
			pulse(4'h1);
			mstep(0, 1, 1);
		end
		chkall(0);
		// A trigger fall with direction control off reloads and sets the event flag.
		pins[1] <= 1'b1;
		apb(0, udt_pkg::IDX_CFG, 1'b1, 8'h00);
		apb(0, udt_pkg::IDX_CTRL, 1'b1, 8'h0E);
		wrap_m[0] = 0;
		pulse(4'h2);
		cnt_m[0] = rel_m[0];
		exf_m[0] = 1;
		chkall(0);
		// Square wave on the undivided clock; 60 steps hold three wraps, none at the stop.
		d = wn[0];
		cnt_m[0] = 65520;
		rel_m[0] = 65520;
		wr16(0, udt_pkg::IDX_RCAP_LO, 16'hFFF0);
		wr16(0, udt_pkg::IDX_CNT_LO, 16'hFFF0);
		apb(0, udt_pkg::IDX_CFG, 1'b1, 8'h0E);
		apb(0, udt_pkg::IDX_CTRL, 1'b1, 8'h04);
		repeat (57) @(posedge pclk);
		apb(0, udt_pkg::IDX_CTRL, 1'b1, 8'h00);
		repeat (60) mstep(0, 0, 1);
		wrap_m[0] = 0;
		exf_m[0] = 0;
		chkall(0);
		chk(16'(ta), 16'((wn[0] - d + 1) % 2));
		// Each tick source gives about its share of steps in a fixed window.
		foreach (divs[k])
		begin
			wr16(1, udt_pkg::IDX_CNT_LO, 16'h0000);
			apb(1, udt_pkg::IDX_CFG, 1'b1, 8'(k << 3));
			apb(1, udt_pkg::IDX_CTRL, 1'b1, 8'h04);
			repeat (120) @(posedge pclk);
			apb(1, udt_pkg::IDX_CTRL, 1'b1, 8'h00);
			rd16(1, udt_pkg::IDX_CNT_LO, v);
			d = int'(v) - 123 / divs[k];
			chk(16'(d * d <= 9), 16'h0001);
		end
		final_report();
	end

endmodule // testbench
